// file: inc/clk_mode_pkg.sv
package clk_mode_pkg;

  // System clock and oscillator timing
  localparam int CLK_PERIOD_NS      = 25;
  localparam int OSC_PERIOD_MAX_NS  = 500;
  // Longest time, so rounded down
  localparam int OSC_PERIOD_MAX_CYC = OSC_PERIOD_MAX_NS / CLK_PERIOD_NS;
  // Two missing oscillator periods count as a lost input
  localparam int OSC_TIMEOUT_CYC    = 2 * OSC_PERIOD_MAX_CYC;

  // Widths
  localparam int PERIOD_W = 6;
  localparam int ACC_W    = PERIOD_W + 2;
  localparam int FX2_W    = 4;
  localparam int WIN_W    = 3;
  localparam int TOG_W    = 6;
  localparam int LOCK_W   = 2;

  // Loop tuning
  localparam logic [PERIOD_W-1:0] PERIOD_INIT  = 6'h10;
  localparam logic [PERIOD_W-1:0] PERIOD_MAX   = 6'h3F;
  localparam logic [PERIOD_W-1:0] PERIOD_ONE   = 6'h01;
  localparam logic [PERIOD_W-1:0] TIMEOUT_CYC  =
    PERIOD_W'(OSC_TIMEOUT_CYC);
  localparam logic [PERIOD_W-1:0] LOCK_TOL     = 6'h01;
  localparam logic [ACC_W-1:0]    PHASE_TRIM   = 8'h01;
  localparam logic [LOCK_W-1:0]   LOCK_WINDOWS = 2'h3;
  localparam logic [TOG_W-1:0]    TOG_MAX      = 6'h3F;
  localparam logic [TOG_W-1:0]    TOG_ONE      = 6'h01;

  // Strap encodings
  localparam logic [2:0] STRAP_X2_5     = 3'h0;
  localparam logic [2:0] STRAP_PRESCALE = 3'h1;
  localparam logic [2:0] STRAP_X1_5     = 3'h2;
  localparam logic [2:0] STRAP_DIRECT   = 3'h3;
  localparam logic [2:0] STRAP_X5       = 3'h4;
  localparam logic [2:0] STRAP_X2       = 3'h5;
  localparam logic [2:0] STRAP_X3       = 3'h6;
  localparam logic [2:0] STRAP_X4       = 3'h7;

  // Factor times two, per strap
  localparam logic [FX2_W-1:0] FX2_X1   = 4'h2;
  localparam logic [FX2_W-1:0] FX2_X1_5 = 4'h3;
  localparam logic [FX2_W-1:0] FX2_X2   = 4'h4;
  localparam logic [FX2_W-1:0] FX2_X2_5 = 4'h5;
  localparam logic [FX2_W-1:0] FX2_X3   = 4'h6;
  localparam logic [FX2_W-1:0] FX2_X4   = 4'h8;
  localparam logic [FX2_W-1:0] FX2_X5   = 4'hA;
  localparam logic [FX2_W-1:0] FX2_HALF = 4'h1;

  // Realignment window in oscillator transitions
  localparam logic [WIN_W-1:0] WIN_X1_5 = 3'h2;
  localparam logic [WIN_W-1:0] WIN_X2   = 3'h2;
  localparam logic [WIN_W-1:0] WIN_X2_5 = 3'h4;
  localparam logic [WIN_W-1:0] WIN_X3   = 3'h3;
  localparam logic [WIN_W-1:0] WIN_X4   = 3'h4;
  localparam logic [WIN_W-1:0] WIN_X5   = 3'h5;
  localparam logic [WIN_W-1:0] WIN_ONE  = 3'h1;

  // CPU clock edges expected per window
  localparam logic [TOG_W-1:0] TOG_X1_5 = 6'h03;
  localparam logic [TOG_W-1:0] TOG_X2   = 6'h04;
  localparam logic [TOG_W-1:0] TOG_X2_5 = 6'h0A;
  localparam logic [TOG_W-1:0] TOG_X3   = 6'h09;
  localparam logic [TOG_W-1:0] TOG_X4   = 6'h10;
  localparam logic [TOG_W-1:0] TOG_X5   = 6'h19;

  typedef enum logic [2:0] {
    MODE_PRESCALE = 3'h1,
    MODE_DIRECT   = 3'h2,
    MODE_LOOP     = 3'h4
  } mode_t;

endpackage : clk_mode_pkg

// file: verilog/input_sync.sv
`timescale 1ns/1ps
module input_sync #(
  parameter int WIDTH = 1
) (
  // Clock
  input  wire logic             clk,
  // Asynchronous levels
  input  wire logic [WIDTH-1:0] din,
  // Filtered levels
  output logic      [WIDTH-1:0] dout
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic lvl_q;
      // No reset: straps must be seen while reset is held
      always_ff @(posedge clk) begin
        s1_q <= din[i];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (s2_q == s3_q) begin
          lvl_q <= s3_q;
        end
      end
      assign dout[i] = lvl_q;
    end
  endgenerate

endmodule : input_sync

// file: verilog/loop_nco.sv
`timescale 1ns/1ps
module loop_nco
  import clk_mode_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // Control
  input  wire logic                run,
  input  wire logic [FX2_W-1:0]    step,
  input  wire logic [PERIOD_W-1:0] period,
  input  wire logic                advance,
  input  wire logic                retard,
  // Output
  output logic                     tog,
  output logic                     clk_out
);

  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] base;
  logic [ACC_W-1:0] sum;
  logic [ACC_W-1:0] per_ext;
  logic             wrap;
  logic             tog_q;
  logic             clk_q;

  assign per_ext = {{(ACC_W-PERIOD_W){1'b0}}, period};

  // Phase nudged by one unit only, never a jump
  always_comb begin
    base = acc_q;
    if (advance) begin
      base = acc_q + PHASE_TRIM; // RULE_06
    end else if (retard && (acc_q >= PHASE_TRIM)) begin
      base = acc_q - PHASE_TRIM; // RULE_06
    end
    sum  = base + {{(ACC_W-FX2_W){1'b0}}, step};
    wrap = (sum >= per_ext);
  end

  // step edges per oscillator period of period cycles
  always_ff @(posedge clk) begin
    if (srst || !run) begin
      acc_q <= '0;
      tog_q <= 1'b0;
      clk_q <= 1'b0;
    end else begin
      tog_q <= wrap;
      if (wrap) begin
        acc_q <= sum - per_ext; // RULE_04
        clk_q <= ~clk_q;
      end else begin
        acc_q <= sum;
      end
    end
  end

  assign tog     = tog_q;
  assign clk_out = clk_q;

endmodule : loop_nco

// file: verilog/cpu_clock_mode_generator.sv
// Summary of operation
// RULE_01: Strap 001 at reset gives a CPU clock of the oscillator halved.
// RULE_02: In prescaler mode each CPU clock phase lasts one oscillator period.
// RULE_03: Any strap other than 001 and 011 enables the loop as CPU clock.
// RULE_04: Loop mode runs the CPU clock at oscillator times strap factor.
// RULE_05: In loop mode the clock is realigned every F oscillator transitions; the code uses 2 for x1.5 and 4 for x2.5.
// RULE_06: Each realignment moves the CPU clock gradually, never abruptly.
// RULE_07: The loop keeps trimming its output to stay locked to the input.
// RULE_08: Strap 011 at reset disables the loop and passes the input through.
// RULE_09: In direct drive the CPU clock phases follow the input duty cycle.
// RULE_10: In direct drive two consecutive phases span one oscillator period.
// RULE_11: The mode comes from the strap pins, held stable during reset.
// RULE_12: Straps 111 to 000 select x4, x3, x2, x5, direct, x1.5, /2, x2.5.
// RULE_13: The strap value is latched at reset release and held until reset.
`timescale 1ns/1ps
module cpu_clock_mode_generator
  import clk_mode_pkg::*;
(
  // Clock and reset
  input  wire logic                oscillator_input_pin,
  input  wire logic                clk,
  input  wire logic                srst,
  // Reset straps
  input  wire logic [2:0]          clock_mode_strap_pins,
  // CPU clock
  output logic                     cpu_clk,
  output logic                     cpu_clock_phase,
  // Status
  output mode_t                    clock_mode,
  output logic                     pll_enable,
  output logic [FX2_W-1:0]         clock_factor_x2,
  output logic                     loop_locked,
  output logic                     osc_lost
);

  // Strap tables
  function automatic logic [FX2_W-1:0] factor_of(input logic [2:0] s);
    case (s)
      STRAP_X4:       factor_of = FX2_X4; // RULE_12
      STRAP_X3:       factor_of = FX2_X3;
      STRAP_X2:       factor_of = FX2_X2;
      STRAP_X5:       factor_of = FX2_X5;
      STRAP_DIRECT:   factor_of = FX2_X1;
      STRAP_X1_5:     factor_of = FX2_X1_5;
      STRAP_PRESCALE: factor_of = FX2_HALF;
      STRAP_X2_5:     factor_of = FX2_X2_5;
      default:        factor_of = FX2_X4;
    endcase
  endfunction : factor_of

  // Fractional factors use the shortest even window not below the factor
  function automatic logic [WIN_W-1:0] window_of(input logic [2:0] s);
    case (s)
      STRAP_X4:   window_of = WIN_X4; // RULE_05
      STRAP_X3:   window_of = WIN_X3;
      STRAP_X2:   window_of = WIN_X2;
      STRAP_X5:   window_of = WIN_X5;
      STRAP_X1_5: window_of = WIN_X1_5;
      STRAP_X2_5: window_of = WIN_X2_5;
      default:    window_of = WIN_ONE;
    endcase
  endfunction : window_of

  function automatic logic [TOG_W-1:0] edges_of(input logic [2:0] s);
    case (s)
      STRAP_X4:   edges_of = TOG_X4;
      STRAP_X3:   edges_of = TOG_X3;
      STRAP_X2:   edges_of = TOG_X2;
      STRAP_X5:   edges_of = TOG_X5;
      STRAP_X1_5: edges_of = TOG_X1_5;
      STRAP_X2_5: edges_of = TOG_X2_5;
      default:    edges_of = TOG_ONE;
    endcase
  endfunction : edges_of

  function automatic mode_t mode_of(input logic [2:0] s);
    case (s)
      STRAP_PRESCALE: mode_of = MODE_PRESCALE; // RULE_01
      STRAP_DIRECT:   mode_of = MODE_DIRECT; // RULE_08
      default:        mode_of = MODE_LOOP; // RULE_03
    endcase
  endfunction : mode_of

  // Synchronised inputs
  logic                osc_lvl;
  logic [2:0]          strap_lvl;

  // Strap and mode state
  logic [2:0]          strap_q;
  mode_t               mode_q;
  logic                pll_en_q;
  logic [FX2_W-1:0]    factor_q;
  logic [WIN_W-1:0]    win_q;
  logic [TOG_W-1:0]    expect_q;

  // Oscillator edges and prescaler
  logic                osc_prev_q;
  logic                osc_rise;
  logic                osc_edge;
  logic                presc_q;

  // Period measurement
  logic [PERIOD_W-1:0] per_cnt_q;
  logic [PERIOD_W-1:0] per_meas_q;
  logic                have_first_q;
  logic                meas_new_q;
  logic                lost_q;

  // Loop control
  logic                run_q;
  logic [PERIOD_W-1:0] period_est_q;
  logic [WIN_W-1:0]    trans_cnt_q;
  logic                realign;
  logic [TOG_W-1:0]    tog_cnt_q;
  logic [TOG_W-1:0]    tog_now;
  logic                adv_q;
  logic                ret_q;
  logic [PERIOD_W-1:0] per_diff;
  logic [LOCK_W-1:0]   lock_cnt_q;
  logic                locked_q;
  logic                loop_tog;
  logic                loop_clk;

  // Output stage
  logic                cpu_clk_d;
  logic                cpu_clk_q;
  logic                phase_q;

  input_sync #(
    .WIDTH (1)
  ) u_osc_sync (
    .clk  (clk),
    .din  (oscillator_input_pin),
    .dout (osc_lvl)
  );

  input_sync #(
    .WIDTH (3)
  ) u_strap_sync (
    .clk  (clk),
    .din  (clock_mode_strap_pins),
    .dout (strap_lvl)
  );

  // Straps follow the pins only while reset is held
  always_ff @(posedge clk) begin
    if (srst) begin
      strap_q <= strap_lvl; // RULE_11
    end
  end // RULE_13

  always_ff @(posedge clk) begin
    if (srst) begin
      mode_q   <= mode_of(strap_lvl); // RULE_11
      pll_en_q <= 1'b0;
      factor_q <= factor_of(strap_lvl);
      win_q    <= window_of(strap_lvl);
      expect_q <= edges_of(strap_lvl);
    end else begin
      mode_q   <= mode_of(strap_q); // RULE_13
      pll_en_q <= (mode_of(strap_q) == MODE_LOOP); // RULE_03
      factor_q <= factor_of(strap_q); // RULE_12
      win_q    <= window_of(strap_q);
      expect_q <= edges_of(strap_q);
    end
  end

  assign osc_rise = osc_lvl & ~osc_prev_q;
  assign osc_edge = osc_lvl ^ osc_prev_q;

  // Tracks the pin through reset too, so release gives no false rise
  always_ff @(posedge clk) begin
    osc_prev_q <= osc_lvl;
  end

  // One CPU phase per oscillator period
  always_ff @(posedge clk) begin
    if (srst) begin
      presc_q <= 1'b0;
    end else if (osc_rise) begin
      presc_q <= ~presc_q; // RULE_02
    end
  end

  // First period after reset or loss is partial, so discarded
  always_ff @(posedge clk) begin
    if (srst) begin
      per_cnt_q    <= '0;
      per_meas_q   <= PERIOD_INIT;
      have_first_q <= 1'b0;
      meas_new_q   <= 1'b0;
      lost_q       <= 1'b0;
    end else begin
      meas_new_q <= 1'b0;
      if (osc_rise) begin
        per_cnt_q    <= '0;
        have_first_q <= 1'b1;
        lost_q       <= 1'b0;
        if (have_first_q) begin
          per_meas_q <= per_cnt_q + PERIOD_ONE;
          meas_new_q <= 1'b1;
        end
      end else if (per_cnt_q >= TIMEOUT_CYC) begin
        have_first_q <= 1'b0;
        lost_q       <= 1'b1;
      end else begin
        per_cnt_q <= per_cnt_q + PERIOD_ONE;
      end
    end
  end

  // Transitions counted per realignment window
  assign realign = run_q && osc_edge
                && (trans_cnt_q == (win_q - WIN_ONE)); // RULE_05

  always_ff @(posedge clk) begin
    if (srst || !run_q) begin
      trans_cnt_q <= '0;
    end else if (realign) begin
      trans_cnt_q <= '0;
    end else if (osc_edge) begin
      trans_cnt_q <= trans_cnt_q + WIN_ONE;
    end
  end

  // Loop starts on the first full measurement, stops on loss
  always_ff @(posedge clk) begin
    if (srst) begin
      run_q        <= 1'b0;
      period_est_q <= PERIOD_INIT;
    end else if (!pll_en_q || lost_q) begin
      run_q <= 1'b0;
    end else if (!run_q) begin
      if (meas_new_q) begin
        run_q        <= 1'b1;
        period_est_q <= per_meas_q;
      end
    end else if (realign) begin
      // One step per window keeps frequency changes smooth
      if (per_meas_q > period_est_q) begin
        period_est_q <= period_est_q + PERIOD_ONE; // RULE_07
      end else if ((per_meas_q < period_est_q)
                   && (period_est_q > PERIOD_ONE)) begin
        period_est_q <= period_est_q - PERIOD_ONE; // RULE_06
      end
    end
  end

  // Edges of the CPU clock seen in the current window
  assign tog_now = (tog_cnt_q == TOG_MAX) ? TOG_MAX
                 : (loop_tog ? tog_cnt_q + TOG_ONE : tog_cnt_q);

  always_ff @(posedge clk) begin
    if (srst || !run_q) begin
      tog_cnt_q <= '0;
    end else if (realign) begin
      tog_cnt_q <= '0;
    end else begin
      tog_cnt_q <= tog_now;
    end
  end

  // Phase error sets only the direction of a one-unit nudge
  always_ff @(posedge clk) begin
    if (srst || !run_q) begin
      adv_q <= 1'b0;
      ret_q <= 1'b0;
    end else begin
      adv_q <= realign && (tog_now < expect_q); // RULE_05
      ret_q <= realign && (tog_now > expect_q); // RULE_06
    end
  end

  assign per_diff = (per_meas_q >= period_est_q)
                  ? per_meas_q - period_est_q
                  : period_est_q - per_meas_q;

  always_ff @(posedge clk) begin
    if (srst || !run_q) begin
      lock_cnt_q <= '0;
      locked_q   <= 1'b0;
    end else if (realign) begin
      if ((tog_now == expect_q) && (per_diff <= LOCK_TOL)) begin
        if (lock_cnt_q != LOCK_WINDOWS) begin
          lock_cnt_q <= lock_cnt_q + 2'h1;
        end
        locked_q <= (lock_cnt_q >= (LOCK_WINDOWS - 2'h1)); // RULE_07
      end else begin
        lock_cnt_q <= '0;
        locked_q   <= 1'b0;
      end
    end
  end

  // Limitation: at most one loop edge per system clock
  loop_nco u_nco (
    .clk     (clk),
    .srst    (srst),
    .run     (run_q),
    .step    (factor_q),
    .period  (period_est_q),
    .advance (adv_q),
    .retard  (ret_q),
    .tog     (loop_tog),
    .clk_out (loop_clk)
  );

  // Clock source select
  always_comb begin
    case (mode_q)
      MODE_PRESCALE: cpu_clk_d = presc_q; // RULE_01
      MODE_DIRECT:   cpu_clk_d = osc_lvl; // RULE_09 RULE_10
      MODE_LOOP:     cpu_clk_d = loop_clk; // RULE_03 RULE_04
      default:       cpu_clk_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_clk_q <= 1'b0;
      phase_q   <= 1'b0;
    end else begin
      cpu_clk_q <= cpu_clk_d;
      phase_q   <= cpu_clk_d ^ cpu_clk_q;
    end
  end

  assign cpu_clk         = cpu_clk_q;
  assign cpu_clock_phase = phase_q;
  assign clock_mode      = mode_q;
  assign pll_enable      = pll_en_q;
  assign clock_factor_x2 = factor_q;
  assign loop_locked     = locked_q;
  assign osc_lost        = lost_q;

endmodule : cpu_clock_mode_generator

// file: test/cpu_clock_mode_chk.sv
`timescale 1ns/1ps
module cpu_clock_mode_chk
  import clk_mode_pkg::*;
(
  // Clock and reset
  input wire logic             oscillator_input_pin,
  input wire logic             clk,
  input wire logic             srst,
  // Reset straps
  input wire logic [2:0]       clock_mode_strap_pins,
  // CPU clock
  input wire logic             cpu_clk,
  input wire logic             cpu_clock_phase,
  // Status
  input wire mode_t            clock_mode,
  input wire logic             pll_enable,
  input wire logic [FX2_W-1:0] clock_factor_x2,
  input wire logic             loop_locked,
  input wire logic             osc_lost
);
  logic       pin_q;
  logic       clk_q;
  logic [6:0] age_q;
  logic [6:0] rise_q;
  logic [6:0] per_q;
  logic [6:0] run_q;
  logic [6:0] prev_q;
  logic [1:0] seen_q;
  wire  [6:0] len = run_q + 7'h01;
  wire        chg = cpu_clk != clk_q;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  // Cycles since the oscillator pin last moved
  always_ff @(posedge clk) begin
    pin_q <= oscillator_input_pin;
    if (srst || oscillator_input_pin != pin_q) age_q <= 7'h00;
    else if (age_q != 7'h7F) age_q <= age_q + 7'h01;
  end

  // Oscillator period, rise to rise; zero until one full period seen
  always_ff @(posedge clk) begin
    if (srst) begin
      rise_q <= 7'h7F;
      per_q  <= 7'h00;
    end else if (oscillator_input_pin && !pin_q) begin
      per_q  <= (rise_q == 7'h7F) ? 7'h00 : rise_q + 7'h01;
      rise_q <= 7'h00;
    end else if (rise_q != 7'h7F) rise_q <= rise_q + 7'h01;
  end

  // Phase lengths; first phases skipped, they start at reset release
  always_ff @(posedge clk) begin
    clk_q <= cpu_clk;
    if (srst) begin
      run_q  <= 7'h00;
      prev_q <= 7'h00;
      seen_q <= 2'h0;
    end else if (chg) begin
      prev_q <= len;
      run_q  <= 7'h00;
      if (seen_q != 2'h3) seen_q <= seen_q + 2'h1;
    end else if (run_q != 7'h7F) run_q <= run_q + 7'h01;
  end

  chk_reset_quiet: assert property ($fell(srst) |->
    !cpu_clk && !pll_enable && !loop_locked && !osc_lost)
    else $error("outputs not quiet after reset");
  chk_phase_pulse: assert property (
    cpu_clock_phase == chg)
    else $error("phase pulse not tied to cpu clock edge");
  chk_mode_hold: assert property (
    !$past(srst) && !$past(srst, 2) |->
    $stable(clock_mode) && $stable(clock_factor_x2))
    else $error("mode changed outside reset");
  chk_pll_mode: assert property (!$past(srst) |->
    pll_enable == (clock_mode == MODE_LOOP))
    else $error("loop enable does not match mode");
  chk_factor_map: assert property (
    (clock_mode == MODE_PRESCALE) == (clock_factor_x2 == FX2_HALF) &&
    (clock_mode == MODE_DIRECT) == (clock_factor_x2 == FX2_X1))
    else $error("factor does not match mode");
  chk_direct_follow: assert property (
    clock_mode == MODE_DIRECT && chg && seen_q != 2'h0 |->
    age_q inside {[2:6]} && cpu_clk == oscillator_input_pin)
    else $error("direct clock not following oscillator");
  chk_direct_pair: assert property (
    clock_mode == MODE_DIRECT && chg && seen_q == 2'h3 && per_q != 7'h00 |->
    len + prev_q inside {[per_q - 7'h01:per_q + 7'h01]})
    else $error("two direct phases differ from oscillator period");
  chk_presc_phase: assert property (
    clock_mode == MODE_PRESCALE && chg && seen_q == 2'h3 |->
    len inside {[per_q - 7'h01:per_q + 7'h01]})
    else $error("prescaler phase differs from oscillator period");
  chk_loop_smooth: assert property (
    pll_enable && loop_locked && !osc_lost && chg && seen_q == 2'h3 |->
    len <= prev_q + 7'h02 && prev_q <= len + 7'h02)
    else $error("abrupt step in loop clock phase");
  chk_lost_time: assert property (
    $rose(osc_lost) |-> rise_q inside {[40:46]})
    else $error("oscillator loss flagged at wrong time");
  chk_lost_stop: assert property (
    pll_enable && osc_lost && $past(osc_lost, 3) |-> !cpu_clk)
    else $error("loop clock runs without oscillator");
endmodule : cpu_clock_mode_chk

// file: test/osc_source.sv
`timescale 1ns/1ps
module osc_source (
  // Control
  input  wire logic       run,
  input  wire logic [9:0] hi_ns,
  input  wire logic [9:0] lo_ns,
  // Oscillator level
  output logic            osc
);
  // Stopped source rests low; offset keeps edges off the clock edge
  initial begin
    osc = 1'b0;
    #3;
    forever begin
      if (run) begin
        osc = 1'b1;
        #(hi_ns);
        osc = 1'b0;
        #(lo_ns);
      end else #25;
    end
  end
endmodule : osc_source

// file: test/cpu_clock_mode_generator_bench.sv
`timescale 1ns/1ps
module cpu_clock_mode_generator_bench;
  import clk_mode_pkg::*;
  logic             clk, srst, osc_run, osc, cpu_clk, cpu_clock_phase;
  logic             pll_enable, loop_locked, osc_lost;
  logic [2:0]       straps;
  logic [9:0]       hi_ns, lo_ns;
  logic [FX2_W-1:0] clock_factor_x2;
  mode_t            clock_mode;
  int               bad_count, cmp_count;
  // Toggles per oscillator period, straps 000 to 111
  localparam logic [3:0] FX [8] = '{4'h5, 4'h1, 4'h3, 4'h2,
                                    4'hA, 4'h4, 4'h6, 4'h8};

  osc_source u_osc_source (.run(osc_run), .hi_ns(hi_ns), .lo_ns(lo_ns),
                           .osc(osc));
  cpu_clock_mode_generator u_cpu_clock_mode_generator (
    .oscillator_input_pin(osc), .clk(clk), .srst(srst),
    .clock_mode_strap_pins(straps), .cpu_clk(cpu_clk),
    .cpu_clock_phase(cpu_clock_phase), .clock_mode(clock_mode),
    .pll_enable(pll_enable), .clock_factor_x2(clock_factor_x2),
    .loop_locked(loop_locked), .osc_lost(osc_lost));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string msg);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: %s seen %0h expected %0h",
               $time, msg, seen, exp);
    end
  endtask : check

  task automatic finish_test;
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  // Straps move after release; the latched mode must not follow
  task automatic do_reset(input logic [2:0] s);
    tick(1);
    straps = s;
    srst = 1'b1;
    tick(20);
    srst = 1'b0;
    tick(2);
    straps = ~s;
  endtask : do_reset

  task automatic wait_lock;
    int n;
    for (n = 0; n < 3000 && loop_locked !== 1'b1; n++) tick(1);
    check(loop_locked, 1'b1, "loop lock");
  endtask : wait_lock

  // Each strap: mode, loop enable, and edge count over 8 periods
  task automatic run_mode(input logic [2:0] s);
    int    n;
    logic  prev;
    mode_t m;
    m = (s == 3'h1) ? MODE_PRESCALE : (s == 3'h3) ? MODE_DIRECT : MODE_LOOP;
    do_reset(s);
    check(clock_mode, m, "mode");
    check(pll_enable, m == MODE_LOOP, "loop enable");
    check(clock_factor_x2, FX[s], "factor");
    if (m == MODE_LOOP) wait_lock();
    else tick(40);
    n = 0;
    prev = cpu_clk;
    repeat (128) begin
      tick(1);
      if (cpu_clk !== prev) n++;
      prev = cpu_clk;
    end
    check((n - 8 * int'(FX[s])) inside {[-2:2]}, 1'b1, "edges");
    check(clock_mode, m, "mode held");
  endtask : run_mode

  task automatic duty_test;
    int n;
    hi_ns = 10'd150;
    lo_ns = 10'd250;
    do_reset(3'h3);
    tick(40);
    for (n = 0; n < 40 && cpu_clk !== 1'b0; n++) tick(1);
    for (n = 0; n < 40 && cpu_clk !== 1'b1; n++) tick(1);
    for (n = 0; n < 40 && cpu_clk === 1'b1; n++) tick(1);
    check(n, 6, "direct high time");
  endtask : duty_test

  task automatic lost_test;
    int n;
    hi_ns = 10'd200;
    lo_ns = 10'd200;
    do_reset(3'h7);
    wait_lock();
    osc_run = 1'b0;
    tick(70);
    check(osc_lost, 1'b1, "oscillator lost");
    check(cpu_clk, 1'b0, "loop stopped");
    osc_run = 1'b1;
    for (n = 0; n < 40 && osc_lost !== 1'b0; n++) tick(1);
    check(osc_lost, 1'b0, "oscillator back");
    do_reset(3'h7);
  endtask : lost_test

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    $display("Error at %0t: run hung", $time);
    finish_test();
  end

  initial begin
    bad_count = 0;
    cmp_count = 0;
    srst = 1'b1;
    straps = 3'h7;
    osc_run = 1'b1;
    hi_ns = 10'd200;
    lo_ns = 10'd200;
    for (int s = 0; s < 8; s++) run_mode(3'(s));
    duty_test();
    lost_test();
    finish_test();
  end
endmodule : cpu_clock_mode_generator_bench

bind cpu_clock_mode_generator cpu_clock_mode_chk u_cpu_clock_mode_chk (
  .oscillator_input_pin(oscillator_input_pin), .clk(clk), .srst(srst),
  .clock_mode_strap_pins(clock_mode_strap_pins), .cpu_clk(cpu_clk),
  .cpu_clock_phase(cpu_clock_phase), .clock_mode(clock_mode),
  .pll_enable(pll_enable), .clock_factor_x2(clock_factor_x2),
  .loop_locked(loop_locked), .osc_lost(osc_lost));
